// >>> hdl/global_regs_defines.svh
// Register offsets, field positions, reset values and identity for the global register group.
`ifndef GLOBAL_REGS_DEFINES_SVH
`define GLOBAL_REGS_DEFINES_SVH
`define IDX_RESET_CTRL_LOW 16'h00f6
`define IDX_DEVICE_IDENTITY 16'h00f8
`define IDX_FRAMER_SUM_LOW 16'h00f9
`define IDX_RESET_CTRL_HIGH 16'h20f6
`define IDX_FRAMER_SUM_HIGH 16'h20f9
`define IDX_IRQ_STATUS 16'h2100
`define IDX_IRQ_MASK 16'h2101
`define BIT_FRAMER_RST 0
`define BIT_TESTER_RST 1
`define BIT_LINE_RST 2
`define RESET_CTRL_USED 8'h07
`define RESET_CTRL_INIT 8'h00
`define SUMMARY_INIT 8'h00
`define PART_CODE_DEFAULT 5'h15
`define DIE_REV_DEFAULT 3'h1
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

// >>> hdl/global_regs_pkg.sv
// Types shared by the global register group.
package global_regs_pkg;
  typedef enum logic [2:0] {
    SEL_NONE, SEL_RST_LOW, SEL_RST_HIGH, SEL_IDENT, SEL_SUM_LOW, SEL_SUM_HIGH,
    SEL_IRQ_STATUS, SEL_IRQ_MASK
  } reg_sel_t;
  typedef enum logic {
    WR_IDLE, WR_RESP
  } wr_state_t;
  typedef struct packed {
    logic [7:0] rst_low;
    logic [7:0] rst_high;
    logic [7:0] sum_low;
    logic [7:0] sum_high;
    logic [5:0] irq_status;
    logic [5:0] irq_mask;
    logic aw_held;
    logic [15:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wr_state_t wr_state;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } regs_state_t;
endpackage

// >>> hdl/global_reset_id_irq_status.sv
// Global soft reset, identity and framer interrupt summary registers on AXI4-Lite.
`timescale 1ns/100ps
`include "global_regs_defines.svh"

module global_reset_id_irq_status
  import global_regs_pkg::*;
#(
  parameter logic [4:0] PART_CODE = `PART_CODE_DEFAULT,
  parameter logic [2:0] DIE_REVISION = `DIE_REV_DEFAULT,
  parameter int CHANNELS = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CHANNELS-1:0] framer_irq,
  output logic [CHANNELS-1:0] line_iface_soft_reset,
  output logic [CHANNELS-1:0] tester_soft_reset,
  output logic [CHANNELS-1:0] framer_soft_reset,
  output logic irq
);

  // Decode a word index into a register select; used by both read and write paths.
  // Any index not listed is unmapped, and both channels answer it with an error
  // rather than letting it alias onto a real register.
  function automatic reg_sel_t decode(input logic [15:0] idx);
    case (idx)
      `IDX_RESET_CTRL_LOW: decode = SEL_RST_LOW;
      `IDX_RESET_CTRL_HIGH: decode = SEL_RST_HIGH;
      `IDX_DEVICE_IDENTITY: decode = SEL_IDENT;
      `IDX_FRAMER_SUM_LOW: decode = SEL_SUM_LOW;
      `IDX_FRAMER_SUM_HIGH: decode = SEL_SUM_HIGH;
      `IDX_IRQ_STATUS: decode = SEL_IRQ_STATUS;
      `IDX_IRQ_MASK: decode = SEL_IRQ_MASK;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // Zero-to-one changes of the three used reset bits of one group. The stored
  // value is the reference, so rewriting a one that is already set starts no
  // new reset event; both reset groups use this.
  function automatic logic [2:0] rise_of(input logic [7:0] wr, input logic [7:0] held);
    rise_of = wr[2:0] & ~held[2:0];
  endfunction

  // Selected register in byte lane zero; unmapped words and unused bits read zero.
  // Reading never changes state, so a read of the summaries is free of side effects.
  function automatic logic [7:0] read_byte(input reg_sel_t sel, input regs_state_t st);
    case (sel)
      SEL_RST_LOW: read_byte = st.rst_low;
      SEL_RST_HIGH: read_byte = st.rst_high;
      SEL_IDENT: read_byte = {PART_CODE, DIE_REVISION};
      SEL_SUM_LOW: read_byte = st.sum_low;
      SEL_SUM_HIGH: read_byte = st.sum_high;
      SEL_IRQ_STATUS: read_byte = {2'h0, st.irq_status};
      SEL_IRQ_MASK: read_byte = {2'h0, st.irq_mask};
      default: read_byte = 8'h00;
    endcase
  endfunction

  // Registered state of the whole block except the synchroniser, and its next value.
  regs_state_t s_q;
  regs_state_t s_d;

  // Three-stage synchroniser for the framer lines, one row of flip-flops per stage.
  logic [2:0][CHANNELS-1:0] f_sync_q;

  // Framer lines after the agreement filter, safe to use in the register domain.
  logic [CHANNELS-1:0] f_live;

  // Framer lines come from other clock domains, so each passes three flip-flops.
  // Only stage one reads stage zero, which gives a metastable first stage a full
  // cycle to settle before any decision depends on it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      f_sync_q <= '0;
    end else begin
      f_sync_q[0] <= framer_irq;
      f_sync_q[1] <= f_sync_q[0];
      f_sync_q[2] <= f_sync_q[1];
    end
  end

  // Filtered line per framer: a change counts once stages one and two agree,
  // and the summary bit keeps its old value while they still differ. The price
  // is one more cycle between a framer line and its summary bit.
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_filt
      if (g < 8) begin : g_lo
        // Framers 1 to 8 fall back on the low summary.
        assign f_live[g] = (f_sync_q[1][g] == f_sync_q[2][g]) ? f_sync_q[2][g] :
                           s_q.sum_low[g];
      end else begin : g_hi
        // Framers 9 to 16 fall back on the high summary.
        assign f_live[g] = (f_sync_q[1][g] == f_sync_q[2][g]) ? f_sync_q[2][g] :
                           s_q.sum_high[g - 8];
      end
    end
  endgenerate

  // Next-state logic for the registers and both bus channels. Every variable
  // declared here gets a value at the top, so no path leaves a latch behind.
  always_comb begin
    logic wr_fire;
    logic rd_fire;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [5:0] rise;
    reg_sel_t wsel;
    reg_sel_t rsel;

    // Defaults: nothing fires, nothing rises and all state holds.
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    wbyte = 8'h00;
    rbyte = 8'h00;
    rise = 6'h00;
    wsel = SEL_NONE;
    rsel = SEL_NONE;
    s_d = s_q;

    // Live framer summaries, framer n at bit n-1.
    // They are rewritten every cycle from the filtered lines, so no bus write can
    // reach them; a bit falls only when the framer itself drops its line.
    s_d.sum_low = f_live[7:0];
    s_d.sum_high = f_live[15:8];

    // Write address and write data are captured independently and in either
    // order. Each ready falls once its item is held, so a master that offers
    // one channel early simply waits for the other.
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr[17:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end

    // The write is carried out one cycle after both halves are held. Decoding
    // the held address keeps the register update off the bus input path, at the
    // cost of one cycle of response latency.
    wr_fire = (s_q.wr_state == WR_IDLE) && s_q.aw_held && s_q.w_held;
    wsel = decode(s_q.aw_addr);
    wbyte = s_q.w_data[7:0];

    // Write channel: idle until a write fires, then answer until it is taken.
    case (s_q.wr_state)
      WR_IDLE: begin
        if (wr_fire) begin
          // Free both capture slots and raise the response.
          s_d.aw_held = 1'b0;
          s_d.w_held = 1'b0;
          s_d.wr_state = WR_RESP;
          // Unmapped words answer with an error; read-only words answer OKAY.
          s_d.bresp = (wsel == SEL_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
          // Only byte lane zero carries register bits; without its strobe the
          // write is answered but changes nothing.
          if (s_q.w_strb[0]) begin
            case (wsel)
              SEL_RST_LOW: begin
                // Stored value held until rewritten; unused bits dropped.
                s_d.rst_low = wbyte & `RESET_CTRL_USED;
                rise[2:0] = rise_of(wbyte, s_q.rst_low);
              end
              SEL_RST_HIGH: begin
                // Same handling for channels 9 to 16.
                s_d.rst_high = wbyte & `RESET_CTRL_USED;
                rise[5:3] = rise_of(wbyte, s_q.rst_high);
              end
              SEL_IRQ_MASK: begin
                // Mask bits line up with the status bits.
                s_d.irq_mask = wbyte[5:0];
              end
              SEL_IRQ_STATUS: begin
                // Writing a one clears that status bit; zeros leave bits alone.
                s_d.irq_status = s_q.irq_status & ~wbyte[5:0];
              end
              default: begin
                // Identity and summaries ignore writes.
                s_d.irq_mask = s_q.irq_mask;
              end
            endcase
          end
        end
      end
      WR_RESP: begin
        // The response stands until the master signals that it has taken it.
        if (s_axi_bready) begin
          s_d.wr_state = WR_IDLE;
        end
      end
      default: begin
        s_d.wr_state = WR_IDLE;
      end
    endcase

    // Rising edges set sticky status; a set in the same cycle as a clear wins.
    s_d.irq_status = s_d.irq_status | rise;

    // Read channel: one read at a time. The live address is decoded because
    // arready already guarantees that no earlier answer is still waiting.
    rd_fire = s_axi_arvalid && s_axi_arready;
    rsel = decode(s_axi_araddr[17:2]);
    rbyte = read_byte(rsel, s_q);

    // The answer is registered and stands until rready; upper bits read zero.
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = {24'h000000, rbyte};
      s_d.rresp = (rsel == SEL_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // One register for all state but the synchroniser; synchronous active-low reset.
  // The reset bits and summaries are named again here so that their documented
  // reset values stay visible even though the whole struct starts at zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.rst_low <= `RESET_CTRL_INIT;
      s_q.rst_high <= `RESET_CTRL_INIT;
      s_q.sum_low <= `SUMMARY_INIT;
      s_q.sum_high <= `SUMMARY_INIT;
      s_q.wr_state <= WR_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus handshakes: address and data accepted once each until the write completes.
  // The readies are combinational from state only, never from the valids, so no
  // loop through the master's logic can form.
  assign s_axi_awready = !s_q.aw_held && (s_q.wr_state == WR_IDLE);
  assign s_axi_wready = !s_q.w_held && (s_q.wr_state == WR_IDLE);

  // Write answer straight from registers, steady while it stands.
  assign s_axi_bvalid = (s_q.wr_state == WR_RESP);
  assign s_axi_bresp = s_q.bresp;

  // Read side: a new address is refused while an answer is still standing.
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // Soft resets fan out per group of eight and hold while the stored bit is one.
  // They are plain levels from flip-flops; the channel logic behind them sees no
  // pulse, so a reset lasts exactly as long as software leaves the bit set.
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_rst
      if (g < 8) begin : g_low
        assign line_iface_soft_reset[g] = s_q.rst_low[`BIT_LINE_RST];
        assign tester_soft_reset[g] = s_q.rst_low[`BIT_TESTER_RST];
        assign framer_soft_reset[g] = s_q.rst_low[`BIT_FRAMER_RST];
      end else begin : g_high
        assign line_iface_soft_reset[g] = s_q.rst_high[`BIT_LINE_RST];
        assign tester_soft_reset[g] = s_q.rst_high[`BIT_TESTER_RST];
        assign framer_soft_reset[g] = s_q.rst_high[`BIT_FRAMER_RST];
      end
    end
  endgenerate

  // Level interrupt while any unmasked reset-start event is pending.
  // Both operands are registers, so the pin cannot glitch between clock edges.
  assign irq = |(s_q.irq_status & s_q.irq_mask);

endmodule

// >>> dv/global_reset_id_irq_status_props.sv
// Concurrent checks on the ports of the global register group.
`timescale 1ns/100ps
module global_reset_id_irq_status_props #(
  parameter logic [4:0] PART_CODE = 5'h00,
  parameter logic [2:0] DIE_REVISION = 3'h0,
  parameter int CHANNELS = 16
) (
  input logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input logic s_axi_rready,
  input logic [17:0] s_axi_araddr,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_bresp, s_axi_rresp,
  input logic [CHANNELS-1:0] line_iface_soft_reset, tester_soft_reset, framer_soft_reset
);
  // A group of eight channels is reset as one, so a byte is all ones or all zeros.
  function automatic logic whole(input logic [7:0] v);
    return v == 8'h00 || v == 8'hff;
  endfunction
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  // Handshake timing and holding of the answers.
  property p_wr_answer; s_wr_take |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer; s_rd_take |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
  // Soft resets move only with a write answer and cover whole groups.
  property p_rst_stable; !$rose(s_axi_bvalid) |-> $stable({line_iface_soft_reset,
    tester_soft_reset, framer_soft_reset}); endproperty
  a_rst_stable: assert property (p_rst_stable) else $error("reset moved without write");
  property p_group_whole; whole(line_iface_soft_reset[7:0]) && whole(line_iface_soft_reset[15:8])
    && whole(tester_soft_reset[7:0]) && whole(tester_soft_reset[15:8])
    && whole(framer_soft_reset[7:0]) && whole(framer_soft_reset[15:8]); endproperty
  a_group_whole: assert property (p_group_whole) else $error("split group reset");
  property p_ident; s_rd_take and (s_axi_araddr == 18'h003e0) |=>
    s_axi_rdata == {24'h0, PART_CODE, DIE_REVISION}; endproperty
  a_ident: assert property (p_ident) else $error("identity wrong");
  property p_unmapped; s_rd_take and (s_axi_araddr == 18'h00010) |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
endmodule

bind global_reset_id_irq_status global_reset_id_irq_status_props #(.PART_CODE(PART_CODE),
  .DIE_REVISION(DIE_REVISION), .CHANNELS(CHANNELS)) i_global_reset_id_irq_status_props (.*);

// >>> dv/global_reset_id_irq_status_test.sv
// Self-checking bench for the soft reset, identity and summary registers.
`timescale 1ns/100ps
`include "global_regs_defines.svh"
module global_reset_id_irq_status_test;
  typedef struct {logic [17:0] a; logic [7:0] d, q; logic [1:0] e; logic [5:0] o;} row_t;
  logic aclk, aresetn, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, irq;
  logic [17:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, got;
  logic [1:0] b_e, r_e, resp;
  logic [15:0] fi, lr, tr, fr;
  logic [3:0] w_s;
  int fails = 0, tests_run = 0, cyc = 0;
  // Write d, expect response e, resets o as {line,tester,framer} high then low, read q.
  row_t rows[11] = '{
    '{18'h003d8, 8'hff, 8'h07, 2'h0, 6'h07}, '{18'h083d8, 8'h05, 8'h05, 2'h0, 6'h2f},
    '{18'h003d8, 8'h02, 8'h02, 2'h0, 6'h2a}, '{18'h083d8, 8'h02, 8'h02, 2'h0, 6'h12},
    '{18'h003d8, 8'h00, 8'h00, 2'h0, 6'h10}, '{18'h083d8, 8'h00, 8'h00, 2'h0, 6'h00},
    '{18'h003e0, 8'hff, {`PART_CODE_DEFAULT, `DIE_REV_DEFAULT}, 2'h0, 6'h00},
    '{18'h003e4, 8'hff, 8'h00, 2'h0, 6'h00}, '{18'h00010, 8'h55, 8'h00, 2'h2, 6'h00},
    '{18'h08400, 8'h00, 8'h3f, 2'h0, 6'h00}, '{18'h08404, 8'h21, 8'h21, 2'h0, 6'h00}};
  global_reset_id_irq_status i_global_reset_id_irq_status (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
    .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_e),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_e), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .framer_irq(fi), .line_iface_soft_reset(lr), .tester_soft_reset(tr),
    .framer_soft_reset(fr), .irq(irq));
  // Clock of 100 ns period.
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // A hung handshake would stall forever, so a cycle ceiling ends the run.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      finish_test();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  task finish_test();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Address and data go out together; each drops at the edge it is taken.
  // A nonzero stall keeps bready low for that many cycles of a standing answer.
  task axi_wr(input logic [17:0] a, input logic [7:0] d, input int stall);
    @(posedge aclk);
    aw_a <= a;
    w_d <= {24'h0, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= (stall == 0);
    do begin
      @(posedge aclk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
      if (b_v === 1'b1 && b_r !== 1'b1) begin
        stall--;
        if (stall == 0) b_r <= 1'b1;
      end
    end while (!(b_v === 1'b1 && b_r === 1'b1));
    resp = b_e;
    b_r <= 1'b0;
  endtask
  task axi_rd(input logic [17:0] a);
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar_r) ar_v <= 1'b0;
    end while (r_v !== 1'b1);
    got = r_d;
    resp = r_e;
    r_r <= 1'b0;
  endtask
  // Main sequence: table rows, then interrupt, strobe, summary and mid-run reset cases.
  initial begin
    aresetn <= 1'b0; aw_v <= 1'b0; w_v <= 1'b0; b_r <= 1'b0; ar_v <= 1'b0; r_r <= 1'b0;
    aw_a <= 18'h0; ar_a <= 18'h0; w_d <= 32'h0; fi <= 16'h0;
    w_s <= 4'h1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].d, 0);
      chk(resp, rows[i].e);
      chk({lr[8], tr[8], fr[8], lr[0], tr[0], fr[0]}, rows[i].o);
      axi_rd(rows[i].a);
      chk(got, rows[i].q);
      chk(resp, rows[i].e);
    end
    $display("test done: register rows");
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    axi_wr(18'h08400, 8'h01, 3);
    chk(resp, 32'h0);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    axi_wr(18'h08400, 8'h20, 0);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    axi_rd(18'h08400);
    chk(got, 32'h1e);
    $display("test done: interrupt");
    // Without the strobe of byte lane zero the write is answered but changes nothing.
    w_s <= 4'h0;
    axi_wr(18'h003d8, 8'h05, 0);
    chk(resp, 32'h0);
    chk(lr | tr | fr, 16'h0);
    w_s <= 4'h1;
    axi_rd(18'h003d8);
    chk(got, 32'h0);
    $display("test done: strobe");
    // The framer lines pass a synchroniser, so give them a few cycles to land.
    fi <= 16'h8001;
    repeat (6) @(posedge aclk);
    axi_rd(18'h003e4);
    chk(got, 32'h01);
    axi_rd(18'h083e4);
    chk(got, 32'h80);
    fi <= 16'h0;
    repeat (6) @(posedge aclk);
    axi_rd(18'h083e4);
    chk(got, 32'h00);
    $display("test done: summaries");
    axi_wr(18'h003d8, 8'h07, 0);
    chk(lr & tr & fr, 16'h00ff);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk(lr | tr | fr, 16'h0);
    axi_rd(18'h003d8);
    chk(got, 32'h0);
    $display("test done: mid-run reset");
    finish_test();
  end
endmodule
